/* hdl/ppam_top.sv */
// How it works
// (RQ1) control bit 0 high runs the modulator; low floats both outputs with pull-ups
// (RQ2) control bit 5 selects 10-bit samples; reset value 0 gives 8-bit samples
// (RQ3) 10-bit duty value is the sample byte followed by control bits 7:6
// (RQ4) sample period is always 128 prescaled clocks, in both modes
// (RQ5) control bits 3:2 divide the core clock by 4, 6 or 7
// (RQ6) 10-bit duty clock is core clock for ratio 4, half core clock else
// (RQ7) selected output high for magnitude duty clocks from period start, then low
// (RQ8) sample bit 7 clear pulses positive output, set pulses negative output
// (RQ9) zero magnitude keeps both outputs low all period
// (RQ10) a written sample reaches the outputs at the next period start
// (RQ11) pulses repeat every period from current registers without software
// (RQ12) period is 512, 768 or 896 core clocks; same 128 ticks in both modes
// (RQ13) software treats magnitude 7F as full scale in 8-bit mode
// (RQ14) magnitude beyond the period saturates: output high the whole period
// (RQ15) software limits 10-bit magnitudes to 511, 447 or 383 by ratio
// (RQ16) software updates samples in step with the period
// (RQ17) software clears the power bit before global powerdown
// (RQ18) prescaler codes 00, 01, 10 give ratios 4, 6, 7; code 11 reserved
`timescale 1ns/1ps
`default_nettype none

module ppam_top
	import ppam_pkg::*;
(
	// clock and reset
	input  wire logic          pclk,
	input  wire logic          presetn,
	// register bus
	input  wire ppam_apb_req_s apb_req,
	output ppam_apb_rsp_s      apb_rsp,
	// speaker pins
	output ppam_drive_s        drive
);

	// ----------------------------------------------------------------
	// registers
	// ----------------------------------------------------------------
	ppam_ctrl_s            ctrl;
	logic [7:0]            sample;

	// ----------------------------------------------------------------
	// bus decode
	// ----------------------------------------------------------------
	logic        setup_phase;
	logic        access_done;
	logic        hit_ctrl;
	logic        hit_sample;
	logic        hit_status;
	logic        hit_any;
	logic        wr_lane0;
	logic        wr_ctrl;
	logic        wr_sample;
	logic [31:0] rd_mux;
	logic [31:0] status_word;

	assign setup_phase = apb_req.psel & ~apb_req.penable;
	assign access_done = apb_req.psel & apb_req.penable & apb_rsp.pready;
	assign hit_ctrl    = (apb_req.paddr == CTRL_ADDR);
	assign hit_sample  = (apb_req.paddr == SAMPLE_ADDR);
	assign hit_status  = (apb_req.paddr == STATUS_ADDR);
	assign hit_any     = hit_ctrl | hit_sample | hit_status;
	// control and sample are one byte wide, so only lane 0 carries write data
	assign wr_lane0    = access_done & apb_req.pwrite & apb_req.pstrb[0];
	assign wr_ctrl     = wr_lane0 & hit_ctrl;
	assign wr_sample   = wr_lane0 & hit_sample;

	assign rd_mux = hit_ctrl   ? {24'h00_0000, ctrl} :
	                hit_sample ? {24'h00_0000, sample} :
	                hit_status ? status_word :
	                32'h0000_0000;

	// ----------------------------------------------------------------
	// bus response: one wait-free access phase after every setup
	// ----------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			apb_rsp <= '0;
		end else if (setup_phase) begin
			apb_rsp.pready  <= 1'b1;
			apb_rsp.prdata  <= apb_req.pwrite ? 32'h0000_0000 : rd_mux;
			apb_rsp.pslverr <= ~hit_any;
		end else begin
			apb_rsp.pready  <= 1'b0;
			apb_rsp.pslverr <= 1'b0;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl <= ppam_ctrl_s'(CTRL_RESET); // RQ2
		end else if (wr_ctrl) begin
			ctrl <= ppam_ctrl_s'(apb_req.pwdata[7:0]);
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sample <= SAMPLE_RESET;
		end else if (wr_sample) begin
			sample <= apb_req.pwdata[7:0];
		end
	end

	// ----------------------------------------------------------------
	// sample decode
	// ----------------------------------------------------------------
	logic             new_sign;
	logic [MAG_W-1:0] narrow_mag;
	logic [MAG_W-1:0] wide_mag;
	logic [MAG_W-1:0] new_mag;

	assign new_sign   = sample[SAMPLE_SIGN_BIT]; // RQ8
	// the sign bit is never part of the magnitude in either mode
	assign narrow_mag = {2'b00, sample[SAMPLE_SIGN_BIT-1:0]};
	assign wide_mag   = {sample[SAMPLE_SIGN_BIT-1:0], ctrl.wide_lsbs}; // RQ3
	assign new_mag    = ctrl.wide_sample_select ? wide_mag : narrow_mag; // RQ2

	// ----------------------------------------------------------------
	// period sequencing state
	// ----------------------------------------------------------------
	typedef enum logic {
		SEQ_IDLE,
		SEQ_RUN
	} ppam_seq_e;

	ppam_seq_e           seq;
	logic                run;
	logic                act_wide;
	logic [1:0]          act_presc;
	logic                act_sign;
	logic [PERIOD_W-1:0] period_cnt;
	logic [MAG_W-1:0]    duty_cnt;

	logic                period_tick;
	logic                duty_tick;
	logic                period_end;
	logic                start;
	logic [DIV_W-1:0]    period_div_m1;
	logic [DIV_W-1:0]    duty_div_m1;

	logic                presc_div6;
	logic                presc_div7;
	logic [DIV_W-1:0]    wide_div_m1;

	assign presc_div6 = (act_presc == PRESC_DIV6); // RQ18
	assign presc_div7 = (act_presc == PRESC_DIV7); // RQ18

	// reserved code 11 falls back to the fastest ratio
	assign period_div_m1 = presc_div6 ? DIV6_M1 :
	                       presc_div7 ? DIV7_M1 :
	                       DIV4_M1; // RQ5 RQ18 RQ12

	// only ratio 4 lets the duty count run at the full core clock
	assign wide_div_m1 = (presc_div6 | presc_div7) ? HALF_M1 : FULL_M1; // RQ6
	assign duty_div_m1 = act_wide ? wide_div_m1 : period_div_m1; // RQ5 RQ6

	logic                restart_div;

	assign period_end  = period_tick & (period_cnt == PERIOD_LAST); // RQ4
	// a period begins when switched on or when the last one completes
	assign start       = ctrl.power & (~run | period_end); // RQ1 RQ11
	// both dividers realign at each period start, so every pulse is exact
	assign restart_div = start | ~ctrl.power; // RQ1 RQ4

	// ----------------------------------------------------------------
	// prescalers
	// ----------------------------------------------------------------
	ppam_divider #(
		.W (DIV_W)
	) u_period_div (
		.pclk    (pclk),
		.presetn (presetn),
		.restart (restart_div),
		.div_m1  (period_div_m1),
		.tick    (period_tick)
	);

	ppam_divider #(
		.W (DIV_W)
	) u_duty_div (
		.pclk    (pclk),
		.presetn (presetn),
		.restart (restart_div),
		.div_m1  (duty_div_m1),
		.tick    (duty_tick)
	);

	// ----------------------------------------------------------------
	// next-state logic
	// ----------------------------------------------------------------
	ppam_seq_e           next_seq;
	logic                next_wide;
	logic [1:0]          next_presc;
	logic                next_sign;
	logic [PERIOD_W-1:0] next_period_cnt;
	logic [MAG_W-1:0]    next_duty_cnt;
	logic                next_active;

	// ----------------------------------------------------------------
	// power sequencing
	// ----------------------------------------------------------------
	always_comb begin
		unique case (seq)
			SEQ_IDLE: next_seq = ctrl.power ? SEQ_RUN : SEQ_IDLE; // RQ1
			SEQ_RUN:  next_seq = ctrl.power ? SEQ_RUN : SEQ_IDLE; // RQ1
		endcase
	end

	assign run = (seq == SEQ_RUN);

	// ----------------------------------------------------------------
	// frozen settings and counters
	// ----------------------------------------------------------------
	// mode, ratio and sample are frozen for a whole period
	assign next_wide  = start ? ctrl.wide_sample_select : act_wide;
	assign next_presc = start ? ctrl.prescale : act_presc;
	assign next_sign  = start ? new_sign : act_sign; // RQ10

	assign next_period_cnt = !ctrl.power ? '0 :
	                         start       ? '0 :
	                         period_tick ? period_cnt + PERIOD_W'(1) :
	                         period_cnt; // RQ4

	// a count not spent by period end is reloaded, so the pin stays high
	assign next_duty_cnt = !ctrl.power                 ? '0 :
	                       start                       ? new_mag : // RQ7 RQ10 RQ11
	                       (duty_tick && duty_cnt != '0) ? duty_cnt - MAG_W'(1) :
	                       duty_cnt; // RQ14

	assign next_active = ctrl.power & (next_duty_cnt != '0); // RQ9

	// ----------------------------------------------------------------
	// state registers
	// ----------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			seq <= SEQ_IDLE;
		end else begin
			seq <= next_seq;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			act_wide <= 1'b0;
		end else begin
			act_wide <= next_wide;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			act_presc <= PRESC_DIV4;
		end else begin
			act_presc <= next_presc;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			act_sign <= 1'b0;
		end else begin
			act_sign <= next_sign;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			period_cnt <= '0;
		end else begin
			period_cnt <= next_period_cnt;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			duty_cnt <= '0;
		end else begin
			duty_cnt <= next_duty_cnt;
		end
	end

	// ----------------------------------------------------------------
	// pin drivers
	// ----------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			drive.positive_drive_out  <= 1'b0;
			drive.negative_drive_out  <= 1'b0;
			drive.positive_drive_oe_n <= 1'b1;
			drive.negative_drive_oe_n <= 1'b1;
			drive.pull_up_en          <= 1'b1;
		end else begin
			drive.positive_drive_out  <= next_active & ~next_sign; // RQ7 RQ8
			drive.negative_drive_out  <= next_active & next_sign; // RQ7 RQ8
			drive.positive_drive_oe_n <= ~ctrl.power; // RQ1
			drive.negative_drive_oe_n <= ~ctrl.power; // RQ1
			drive.pull_up_en          <= ~ctrl.power; // RQ1
		end
	end

	// ----------------------------------------------------------------
	// status word
	// ----------------------------------------------------------------
	assign status_word = {16'h0000, 1'b0, period_cnt, 5'h00,
	                      drive.negative_drive_out, drive.positive_drive_out, run};

endmodule : ppam_top

`default_nettype wire

/* hdl/ppam_pkg.sv */
`default_nettype none

package ppam_pkg;

	// ----------------------------------------------------------------
	// register map (index times four gives the byte address)
	// ----------------------------------------------------------------
	localparam int unsigned ADDR_W      = 12;
	localparam logic [7:0]  CTRL_IDX    = 8'hd7;
	localparam logic [7:0]  SAMPLE_IDX  = 8'hd8;
	localparam logic [7:0]  STATUS_IDX  = 8'hd9;
	localparam logic [ADDR_W-1:0] CTRL_ADDR   = {2'b00, CTRL_IDX, 2'b00};
	localparam logic [ADDR_W-1:0] SAMPLE_ADDR = {2'b00, SAMPLE_IDX, 2'b00};
	localparam logic [ADDR_W-1:0] STATUS_ADDR = {2'b00, STATUS_IDX, 2'b00};

	// ----------------------------------------------------------------
	// reset values and field positions
	// ----------------------------------------------------------------
	localparam logic [7:0]  CTRL_RESET      = 8'h00;
	localparam logic [7:0]  SAMPLE_RESET    = 8'h00;
	localparam int unsigned SAMPLE_SIGN_BIT = 7;
	localparam int unsigned MAG_W           = 9;

	// ----------------------------------------------------------------
	// prescaler codes and divide ratios (stored as ratio minus one)
	// ----------------------------------------------------------------
	localparam int unsigned DIV_W      = 3;
	localparam logic [1:0]  PRESC_DIV4 = 2'b00;
	localparam logic [1:0]  PRESC_DIV6 = 2'b01;
	localparam logic [1:0]  PRESC_DIV7 = 2'b10;
	localparam logic [DIV_W-1:0] DIV4_M1 = 3'h3;
	localparam logic [DIV_W-1:0] DIV6_M1 = 3'h5;
	localparam logic [DIV_W-1:0] DIV7_M1 = 3'h6;
	localparam logic [DIV_W-1:0] FULL_M1 = 3'h0;
	localparam logic [DIV_W-1:0] HALF_M1 = 3'h1;

	// ----------------------------------------------------------------
	// sample period
	// ----------------------------------------------------------------
	localparam int unsigned PERIOD_TICKS = 128;
	localparam int unsigned PERIOD_W     = $clog2(PERIOD_TICKS);
	localparam logic [PERIOD_W-1:0] PERIOD_LAST = 7'h7f;

	// ----------------------------------------------------------------
	// carriers
	// ----------------------------------------------------------------
	typedef struct packed {
		logic [1:0] wide_lsbs;
		logic       wide_sample_select;
		logic       spare_hi;
		logic [1:0] prescale;
		logic       spare_lo;
		logic       power;
	} ppam_ctrl_s;

	typedef struct packed {
		logic              psel;
		logic              penable;
		logic              pwrite;
		logic [ADDR_W-1:0] paddr;
		logic [31:0]       pwdata;
		logic [3:0]        pstrb;
	} ppam_apb_req_s;

	typedef struct packed {
		logic [31:0] prdata;
		logic        pready;
		logic        pslverr;
	} ppam_apb_rsp_s;

	typedef struct packed {
		logic positive_drive_out;
		logic positive_drive_oe_n;
		logic negative_drive_out;
		logic negative_drive_oe_n;
		logic pull_up_en;
	} ppam_drive_s;

endpackage : ppam_pkg

`default_nettype wire

/* hdl/ppam_divider.sv */
`timescale 1ns/1ps
`default_nettype none

module ppam_divider #(
	parameter int unsigned W = 3
) (
	// clock and reset
	input  wire logic         pclk,
	input  wire logic         presetn,
	// control
	input  wire logic         restart,
	input  wire logic [W-1:0] div_m1,
	// output
	output logic              tick
);

	logic [W-1:0] count;

	// compare with >= so a ratio lowered mid-count cannot overrun
	assign tick = (count >= div_m1);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			count <= '0;
		end else if (restart || tick) begin
			count <= '0;
		end else begin
			count <= count + W'(1);
		end
	end

endmodule : ppam_divider

`default_nettype wire

/* dv/ppam_props.sv */
`timescale 1ns/1ps
`default_nettype none
module ppam_props
	import ppam_pkg::*;
(
	// clock and reset
	input wire logic          pclk,
	input wire logic          presetn,
	// watched ports
	input wire ppam_apb_req_s apb_req,
	input wire ppam_apb_rsp_s apb_rsp,
	input wire ppam_drive_s   drive
);
	// ----------------
	// helpers
	// ----------------
	wire logic ctrl_wr = apb_req.psel && apb_req.penable && apb_rsp.pready
		&& apb_req.pwrite && apb_req.pstrb[0] && apb_req.paddr == CTRL_ADDR;
	wire logic pins_off = drive.pull_up_en && drive.positive_drive_oe_n
		&& drive.negative_drive_oe_n && !drive.positive_drive_out && !drive.negative_drive_out;
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);

	ready_after_setup_a: assert property (apb_req.psel && !apb_req.penable |=> apb_rsp.pready)
		else $error("no pready after setup");
	ready_single_a: assert property (apb_rsp.pready |=> !apb_rsp.pready)
		else $error("pready held too long");
	error_needs_ready_a: assert property (apb_rsp.pslverr |-> apb_rsp.pready)
		else $error("pslverr without pready");
	upper_zero_a: assert property (apb_rsp.pready && !apb_rsp.pslverr
		&& apb_req.paddr != STATUS_ADDR |-> apb_rsp.prdata[31:8] == 24'h00_0000)
		else $error("read data upper bits set");
	off_float_a: assert property (drive.pull_up_en |-> pins_off)
		else $error("pull-up with a pin driven");
	power_off_a: assert property (ctrl_wr && !apb_req.pwdata[0] |-> ##[1:2] pins_off)
		else $error("pins not released on power off");
	power_on_a: assert property (ctrl_wr && apb_req.pwdata[0] |-> ##[1:2]
		!drive.pull_up_en && !drive.positive_drive_oe_n && !drive.negative_drive_oe_n)
		else $error("pins not driven on power on");
	one_side_a: assert property (!(drive.positive_drive_out && drive.negative_drive_out))
		else $error("both pins high");
endmodule : ppam_props
`default_nettype wire

/* dv/ppam_speaker.sv */
`timescale 1ns/1ps
`default_nettype none
module ppam_speaker
	import ppam_pkg::*;
(
	// pins from the block
	input  wire logic        pclk,
	input  wire ppam_drive_s drive,
	// levels at the cone
	output logic             pos_lvl,
	output logic             neg_lvl
);
	logic wobble = 1'b0;
	always @(posedge pclk) wobble <= ~wobble;
	// a floating pin without pull-up must not look like a held level
	assign pos_lvl = !drive.positive_drive_oe_n ? drive.positive_drive_out
		: (drive.pull_up_en ? 1'b1 : wobble);
	assign neg_lvl = !drive.negative_drive_oe_n ? drive.negative_drive_out
		: (drive.pull_up_en ? 1'b1 : wobble);
endmodule : ppam_speaker
`default_nettype wire

/* dv/push_pull_audio_modulator_test.sv */
`timescale 1ns/1ps
`default_nettype none
module push_pull_audio_modulator_test
	import ppam_pkg::*;
;
	logic          pclk = 1'b0;
	logic          presetn = 1'b0;
	ppam_apb_req_s req = '0;
	ppam_apb_rsp_s rsp;
	ppam_drive_s   drive;
	wire logic     pos_lvl;
	wire logic     neg_lvl;
	logic [31:0]   rd;
	logic          err_seen;
	int            errors = 0;
	int            checks_done = 0;
	int            n;
	int            oth;

	always #20 pclk = ~pclk;
	ppam_top i_dut (.pclk(pclk), .presetn(presetn), .apb_req(req), .apb_rsp(rsp), .drive(drive));
	ppam_speaker i_spk (.pclk(pclk), .drive(drive), .pos_lvl(pos_lvl), .neg_lvl(neg_lvl));

	// ----------------
	// helpers
	// ----------------
	task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
		checks_done++;
		if (got !== exp) begin
			errors++;
			$display("BAD %s expected %0h seen %0h", what, exp, got);
		end
	endtask : check

	task automatic apb(input logic wr, input logic [ADDR_W-1:0] a, input logic [7:0] d);
		@(posedge pclk);
		req <= '{1'b1, 1'b0, wr, a, {24'h00_0000, d}, 4'hf};
		@(posedge pclk);
		req.penable <= 1'b1;
		// no cycle count assumed: only the watchdog ends this wait
		do begin
			@(posedge pclk);
		end while (rsp.pready !== 1'b1);
		rd = rsp.prdata;
		err_seen = rsp.pslverr;
		req.psel <= 1'b0;
		req.penable <= 1'b0;
	endtask : apb

	function automatic logic [7:0] cv(input logic [1:0] lsb, input logic w, input logic [1:0] c);
		return {lsb, w, 1'b0, c, 1'b0, 1'b1};
	endfunction : cv

	function automatic logic pin(input logic neg);
		return neg ? drive.negative_drive_out : drive.positive_drive_out;
	endfunction : pin

	task automatic step(input logic neg);
		@(posedge pclk);
		n++;
		if (pin(!neg) !== 1'b0) oth++;
	endtask : step

	// skips a period so that new settings are latched before timing
	task automatic measure(input logic neg, input int hi_exp, input int per_exp);
		int hi;
		int lo;
		hi = 0;
		lo = 0;
		n = 0;
		repeat (2) begin
			while (pin(neg) !== 1'b0 && n < 4000) step(neg);
			while (pin(neg) !== 1'b1 && n < 4000) step(neg);
		end
		oth = 0;
		while (pin(neg) === 1'b1 && n < 4000) begin step(neg); hi++; end
		while (pin(neg) === 1'b0 && n < 4000) begin step(neg); lo++; end
		check("high time", hi_exp, hi);
		check("period", per_exp, hi + lo);
		check("other pin", 0, oth);
	endtask : measure

	// ----------------
	// scenarios
	// ----------------
	task automatic t_reset;
		check("pins at reset", 5'h0b, drive);
		check("levels at reset", 2'h3, {pos_lvl, neg_lvl});
		apb(1'b0, CTRL_ADDR, 8'h00);
		check("control reset", 32'h0000_0000, rd);
		check("control error", 1'b0, err_seen);
		apb(1'b0, SAMPLE_ADDR, 8'h00);
		check("sample reset", 32'h0000_0000, rd);
		apb(1'b0, 12'h000, 8'h00);
		check("unmapped error", 1'b1, err_seen);
		check("unmapped data", 32'h0000_0000, rd);
		$display("reset done");
	endtask : t_reset

	task automatic t_rates;
		// the reserved code is expected to fall back to ratio 4
		logic [1:0] code [4] = '{2'b11, PRESC_DIV4, PRESC_DIV6, PRESC_DIV7};
		int         ratio [4] = '{4, 4, 6, 7};
		apb(1'b1, SAMPLE_ADDR, 8'h01);
		for (int i = 0; i < 4; i++) begin
			apb(1'b1, CTRL_ADDR, cv(2'b00, 1'b0, code[i]));
			measure(1'b0, ratio[i], 128 * ratio[i]);
		end
		apb(1'b1, SAMPLE_ADDR, 8'hff);
		measure(1'b1, 889, 896);
		$display("rates done");
	endtask : t_rates

	task automatic t_wide;
		apb(1'b1, CTRL_ADDR, cv(2'b11, 1'b1, PRESC_DIV4));
		apb(1'b0, CTRL_ADDR, 8'h00);
		check("control", {24'h00_0000, cv(2'b11, 1'b1, PRESC_DIV4)}, rd);
		apb(1'b0, STATUS_ADDR, 8'h00);
		check("running", 1'b1, rd[0]);
		apb(1'b1, SAMPLE_ADDR, 8'h7f);
		measure(1'b0, 511, 512);
		apb(1'b1, SAMPLE_ADDR, 8'h6f);
		apb(1'b1, CTRL_ADDR, cv(2'b11, 1'b1, PRESC_DIV7));
		measure(1'b0, 894, 896);
		apb(1'b1, SAMPLE_ADDR, 8'hdf);
		apb(1'b1, CTRL_ADDR, cv(2'b11, 1'b1, PRESC_DIV6));
		measure(1'b1, 766, 768);
		$display("wide done");
	endtask : t_wide

	task automatic t_levels;
		int hi;
		apb(1'b1, SAMPLE_ADDR, 8'h7f);
		repeat (1600) step(1'b0);
		oth = 0;
		repeat (800) step(1'b1);
		check("saturated", 800, oth);
		apb(1'b1, CTRL_ADDR, cv(2'b00, 1'b1, PRESC_DIV6));
		apb(1'b1, SAMPLE_ADDR, 8'h00);
		repeat (1600) step(1'b0);
		oth = 0;
		repeat (800) begin
			step(1'b0);
			if (drive.positive_drive_out !== 1'b0) oth++;
		end
		check("both low", 0, oth);
		apb(1'b1, SAMPLE_ADDR, 8'h01);
		n = 0;
		while (drive.positive_drive_out !== 1'b1 && n < 2000) step(1'b0);
		check("lag", 1'b1, n <= 770);
		// rewrite just after a period start: the running pulse keeps its length
		apb(1'b1, SAMPLE_ADDR, 8'h02);
		hi = 0;
		while (pin(1'b0) === 1'b1 && n < 4000) begin
			step(1'b0);
			hi++;
		end
		check("old pulse", 1'b1, hi > 0 && hi < 8);
		while (pin(1'b0) === 1'b0 && n < 4000) step(1'b0);
		hi = 0;
		while (pin(1'b0) === 1'b1 && n < 4000) begin
			step(1'b0);
			hi++;
		end
		check("new pulse", 16, hi);
		apb(1'b1, CTRL_ADDR, 8'h00);
		repeat (3) step(1'b0);
		check("pins off", 5'h0b, drive);
		check("levels off", 2'h3, {pos_lvl, neg_lvl});
		apb(1'b0, STATUS_ADDR, 8'h00);
		check("status off", 32'h0000_0000, rd);
		$display("levels done");
	endtask : t_levels

	task automatic results;
		$display("checks %0d errors %0d", checks_done, errors);
		if (errors == 0 && checks_done > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask : results

	initial begin
		repeat (20) @(posedge pclk);
		presetn <= 1'b1;
		t_reset();
		t_rates();
		t_wide();
		t_levels();
		results();
	end

	initial begin
		repeat (60000) @(posedge pclk);
		errors++;
		$display("watchdog expired");
		results();
	end
endmodule : push_pull_audio_modulator_test

bind ppam_top ppam_props i_props (.pclk(pclk), .presetn(presetn), .apb_req(apb_req),
	.apb_rsp(apb_rsp), .drive(drive));
`default_nettype wire
